/* File: logic/mcf_cfg.svh */
`ifndef MCF_CFG_SVH
`define MCF_CFG_SVH
`define MCF_SERIAL_FRAME_LEN 4'd9
`define MCF_CAN_FRAME_LEN 4'd7
`define MCF_SERIAL_REPLY_LEN 4'd9
`define MCF_CAN_REPLY_LEN 4'd7
`define MCF_ST_OK 8'h64
`define MCF_ST_STORED 8'h65
`define MCF_ST_BAD_SUM 8'h01
`define MCF_ST_BAD_CMD 8'h02
`define MCF_ST_BAD_TYPE 8'h03
`define MCF_ST_BAD_VALUE 8'h04
`define MCF_ST_LOCKED 8'h05
`define MCF_ST_NOT_AVAIL 8'h06
`define MCF_FIFO_DEPTH 8
`define MCF_FIFO_WIDTH 8
`endif

/* File: logic/mcf_pkg.sv */
package mcf_pkg;
	typedef enum logic [3:0] {
		MCF_IDLE = 4'b0001,
		MCF_RECV = 4'b0010,
		MCF_EXEC = 4'b0100,
		MCF_SEND = 4'b1000
	} mcf_state_t;
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] typ;
		logic [7:0] bank;
		logic [31:0] value;
	} mcf_core_t;
endpackage

/* File: logic/mcf_stream_if.sv */
`timescale 1ns/1ps
interface mcf_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

/* File: logic/mcf_fifo.sv */
`timescale 1ns/1ps
module mcf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	mcf_stream_if.snk wr,
	mcf_stream_if.src rd
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;
	assign wr.ready = (cnt_reg != DEPTH[AW:0]);
	assign rd.valid = (cnt_reg != '0);
	assign rd.data = mem[rp_reg];
	assign push = wr.valid && wr.ready;
	assign pop = rd.valid && rd.ready;
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wp_reg] <= wr.data;
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
			end
			if (push && !pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop && !push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule

/* File: logic/mcf_interp.sv */
`include "mcf_cfg.svh"
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Host waits for the whole reply before sending the next command.
// [R2] Module never starts a transmission; it only answers received commands.
// [R3] Transmit enable is high only while a reply is sent.
// [R4] Command core is command, type, bank and four value bytes: seven bytes.
// [R5] Serial frames add a leading address byte and trailing checksum: nine bytes.
// [R6] Value field travels most significant byte first, both directions.
// [R7] Command checksum is the 8-bit sum of the eight preceding bytes.
// [R8] CAN frames drop address and checksum; identifier addresses, CRC checks.
// [R9] Exactly one reply leaves for every accepted command frame.
// [R10] Serial reply: reply addr, module addr, status, command, value, checksum.
// [R11] Reply checksum is the 8-bit sum of all other reply bytes.
// [R12] CAN reply drops address and checksum bytes.
// [R13] Status codes: 100 ok, 101 stored, 1 to 6 error kinds.
// [R14] Serial frames for another address are dropped without a reply.
module mcf_interp (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic can_mode,
	input wire logic [7:0] module_addr,
	input wire logic [7:0] reply_addr,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	output logic cmd_valid,
	output mcf_pkg::mcf_core_t cmd_core,
	input wire logic cmd_done,
	input wire logic [7:0] cmd_status,
	input wire logic [31:0] cmd_result,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	output logic tx_enable
);
	import mcf_pkg::*;

	function automatic logic [7:0] sum8(input logic [7:0] a, input logic [7:0] b);
		sum8 = a + b;
	endfunction

	// Executor codes outside the known set go out as not available [R13]
	function automatic logic [7:0] status_fix(input logic [7:0] s);
		case (s)
			`MCF_ST_OK,
			`MCF_ST_STORED,
			`MCF_ST_BAD_SUM,
			`MCF_ST_BAD_CMD,
			`MCF_ST_BAD_TYPE,
			`MCF_ST_BAD_VALUE,
			`MCF_ST_LOCKED,
			`MCF_ST_NOT_AVAIL: status_fix = s;
			default: status_fix = `MCF_ST_NOT_AVAIL;
		endcase
	endfunction

	mcf_state_t state_reg;
	logic [3:0] idx_reg;
	logic [7:0] sum_reg;
	logic [7:0] addr_reg;
	logic addr_ok_reg;
	logic can_reg;
	mcf_core_t core_reg;
	logic [7:0] status_reg;
	logic [31:0] result_reg;
	logic [3:0] tidx_reg;
	logic [7:0] tsum_reg;
	logic [3:0] rx_len;
	logic [3:0] tx_len;
	logic rx_take;
	logic [3:0] core_pos;
	logic frame_end;
	logic sum_good;
	logic [7:0] tx_byte;
	logic fifo_push;

	mcf_stream_if #(.W(`MCF_FIFO_WIDTH)) fin ();
	mcf_stream_if #(.W(`MCF_FIFO_WIDTH)) fout ();

	mcf_fifo #(.WIDTH(`MCF_FIFO_WIDTH), .DEPTH(`MCF_FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.wr(fin.snk),
		.rd(fout.src)
	);

	// Straps come from pins: two flip-flops, then a settle check so that a
	// multi-bit address is only taken once two samples in a row agree.
	// The price is a few cycles of latency after a strap changes.
	logic [16:0] strap_pins;
	logic [16:0] strap_meta_reg;
	logic [16:0] strap_sync_reg;
	logic [16:0] strap_seen_reg;
	logic [16:0] strap_reg;
	logic can_mode_s;
	logic [7:0] module_addr_s;
	logic [7:0] reply_addr_s;

	assign strap_pins = {can_mode, module_addr, reply_addr};
	assign can_mode_s = strap_reg[16];
	assign module_addr_s = strap_reg[15:8];
	assign reply_addr_s = strap_reg[7:0];

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			strap_meta_reg <= '0;
			strap_sync_reg <= '0;
		end else begin
			strap_meta_reg <= strap_pins;
			strap_sync_reg <= strap_meta_reg;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			strap_seen_reg <= '0;
			strap_reg <= '0;
		end else begin
			strap_seen_reg <= strap_sync_reg;
			if (strap_sync_reg == strap_seen_reg) begin
				strap_reg <= strap_sync_reg;
			end
		end
	end

	// Frame length follows the link kind latched at frame start [R5] [R8]
	assign rx_len = can_reg ? `MCF_CAN_FRAME_LEN : `MCF_SERIAL_FRAME_LEN;
	assign tx_len = can_reg ? `MCF_CAN_REPLY_LEN : `MCF_SERIAL_REPLY_LEN;
	// Receive only while idle or mid-frame; a new frame waits until the reply is out [R1]
	assign rx_ready = (state_reg == MCF_IDLE) || (state_reg == MCF_RECV);
	assign rx_take = rx_valid && rx_ready;
	assign core_pos = can_reg ? idx_reg : idx_reg - 4'd1;
	assign frame_end = rx_take && (idx_reg == rx_len - 4'd1);
	assign sum_good = can_reg || (sum_reg == rx_data); // [R7] [R8]

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= MCF_IDLE;
		end else begin
			unique case (state_reg)
				MCF_IDLE: begin
					if (rx_take) begin
						state_reg <= MCF_RECV;
					end
				end
				MCF_RECV: begin
					if (frame_end) begin
						// Foreign address: no reply at all [R14]
						if (!addr_ok_reg) begin
							state_reg <= MCF_IDLE;
						end else if (!sum_good) begin
							state_reg <= MCF_SEND;
						end else begin
							state_reg <= MCF_EXEC;
						end
					end
				end
				MCF_EXEC: begin
					if (cmd_done) begin
						state_reg <= MCF_SEND;
					end
				end
				MCF_SEND: begin
					// One reply per command, then back to listening [R9]
					// Leave only as the last byte leaves the output register [R3]
					if (tidx_reg == tx_len && !fout.valid && (!tx_valid || tx_ready)) begin
						state_reg <= MCF_IDLE;
					end
				end
			endcase
		end
	end

	// Byte position and running checksum of the incoming frame
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			idx_reg <= 4'h0;
			sum_reg <= 8'h00;
			can_reg <= 1'b0;
			addr_ok_reg <= 1'b0;
			addr_reg <= 8'h00;
		end else if (rx_take) begin
			if (state_reg == MCF_IDLE) begin
				can_reg <= can_mode_s;
				idx_reg <= 4'h1;
				sum_reg <= rx_data; // [R7]
				addr_reg <= can_mode_s ? module_addr_s : rx_data;
				addr_ok_reg <= can_mode_s || (rx_data == module_addr_s); // [R14]
			end else begin
				idx_reg <= frame_end ? 4'h0 : idx_reg + 4'h1;
				sum_reg <= sum8(sum_reg, rx_data);
			end
		end
	end

	// Split the core: command, type, bank, value big-endian [R4] [R6]
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			core_reg <= '0;
		end else if (rx_take) begin
			if (state_reg == MCF_IDLE && can_mode_s) begin
				core_reg.cmd <= rx_data;
			end else if (state_reg == MCF_RECV) begin
				unique case (core_pos)
					4'd0: core_reg.cmd <= rx_data;
					4'd1: core_reg.typ <= rx_data;
					4'd2: core_reg.bank <= rx_data;
					4'd3: core_reg.value[31:24] <= rx_data;
					4'd4: core_reg.value[23:16] <= rx_data;
					4'd5: core_reg.value[15:8] <= rx_data;
					4'd6: core_reg.value[7:0] <= rx_data;
					default: ;
				endcase
			end
		end
	end

	// Command hand-off and the status captured for the reply [R13]
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_valid <= 1'b0;
			status_reg <= 8'h00;
			result_reg <= 32'h0000_0000;
		end else begin
			cmd_valid <= 1'b0;
			if (state_reg == MCF_RECV && frame_end && addr_ok_reg) begin
				if (sum_good) begin
					cmd_valid <= 1'b1;
				end else begin
					status_reg <= `MCF_ST_BAD_SUM; // [R13]
					result_reg <= 32'h0000_0000;
				end
			end else if (state_reg == MCF_EXEC && cmd_done) begin
				status_reg <= status_fix(cmd_status); // [R13]
				result_reg <= cmd_result;
			end
		end
	end
	assign cmd_core = core_reg;

	// Reply byte order; CAN leaves out the reply address and checksum [R10] [R12]
	always_comb begin
		tx_byte = 8'h00;
		unique case (can_reg ? tidx_reg + 4'd1 : tidx_reg)
			4'd0: tx_byte = reply_addr_s;
			4'd1: tx_byte = addr_reg;
			4'd2: tx_byte = status_reg;
			4'd3: tx_byte = core_reg.cmd;
			4'd4: tx_byte = result_reg[31:24]; // [R6]
			4'd5: tx_byte = result_reg[23:16];
			4'd6: tx_byte = result_reg[15:8];
			4'd7: tx_byte = result_reg[7:0];
			4'd8: tx_byte = tsum_reg; // [R11]
			default: tx_byte = 8'h00;
		endcase
	end

	// Reply bytes are queued only in the send state, never unprompted [R2]
	assign fifo_push = (state_reg == MCF_SEND) && (tidx_reg != tx_len);
	assign fin.valid = fifo_push;
	assign fin.data = tx_byte;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tidx_reg <= 4'h0;
			tsum_reg <= 8'h00;
		end else if (state_reg != MCF_SEND) begin
			tidx_reg <= 4'h0;
			tsum_reg <= 8'h00;
		end else if (fifo_push && fin.ready) begin
			tidx_reg <= tidx_reg + 4'h1;
			tsum_reg <= sum8(tsum_reg, tx_byte); // [R11]
		end
	end

	// Output stage registered so data comes from flip-flops
	logic [3:0] out_cnt_reg;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_last <= 1'b0;
			out_cnt_reg <= 4'h0;
		end else begin
			if (tx_valid && tx_ready) begin
				tx_valid <= 1'b0;
				tx_last <= 1'b0;
			end
			if ((!tx_valid || tx_ready) && fout.valid) begin
				tx_valid <= 1'b1;
				tx_data <= fout.data;
				tx_last <= (out_cnt_reg == tx_len - 4'd1);
				out_cnt_reg <= (out_cnt_reg == tx_len - 4'd1) ? 4'h0 : out_cnt_reg + 4'h1;
			end
		end
	end
	assign fout.ready = !tx_valid || tx_ready;

	// Bus driven only while a reply is in flight, else receive [R3]
	assign tx_enable = (state_reg == MCF_SEND) || tx_valid;
endmodule

/* File: tb/mcf_interp_props.sv */
`timescale 1ns/1ps
module mcf_interp_props (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic rx_ready,
	input wire logic cmd_valid,
	input wire logic cmd_done,
	input wire logic tx_valid,
	input wire logic tx_last,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic tx_enable
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence byte_out;
		tx_valid && tx_ready;
	endsequence
	sequence final_out;
		byte_out ##0 tx_last;
	endsequence
	reply_bus_a: assert property (tx_valid |-> tx_enable && !rx_ready)
		else $error("reply byte without bus enable");
	send_deaf_a: assert property (tx_enable |-> !rx_ready)
		else $error("receiving while sending");
	bus_free_a: assert property (final_out |=> ##[0:2] !tx_enable)
		else $error("bus held after reply");
	byte_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply byte dropped");
	one_reply_a: assert property (cmd_done |-> ##[1:4] tx_valid)
		else $error("no reply after execution");
	cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
		else $error("command issued twice");
	exec_quiet_a: assert property (cmd_valid |-> !tx_enable && !rx_ready)
		else $error("bus busy during execution");
	last_valid_a: assert property (tx_last |-> tx_valid)
		else $error("end mark without byte");
endmodule

/* File: tb/mcf_exec_model.sv */
`timescale 1ns/1ps
module mcf_exec_model (
	input wire logic mclk,
	input wire logic cmd_valid,
	input wire mcf_pkg::mcf_core_t cmd_core,
	input wire logic [7:0] status,
	output logic cmd_done,
	output logic [7:0] cmd_status,
	output logic [31:0] cmd_result,
	output logic tx_ready
);
	import mcf_pkg::*;
	initial begin
		cmd_done = 1'b0;
		cmd_status = 8'h00;
		cmd_result = 32'h0;
		tx_ready = 1'b0;
	end
	// Reply sink stalls about one cycle in four
	always @(posedge mclk) begin
		tx_ready <= #1 ($urandom() % 4) != 0;
	end
	// Status and result are only meaningful with the done pulse; garbage otherwise
	always begin
		@(posedge mclk);
		#1;
		if (cmd_valid === 1'b1) begin
			repeat ($urandom_range(4, 0)) @(posedge mclk);
			#1;
			cmd_status = status;
			cmd_result = ~cmd_core.value;
			cmd_done = 1'b1;
			@(posedge mclk);
			#1;
			cmd_done = 1'b0;
			cmd_status = ~status;
			cmd_result = cmd_core.value;
		end
	end
endmodule

/* File: tb/test_mcf_interp.sv */
`timescale 1ns/1ps
module test_mcf_interp;
	import mcf_pkg::*;
	logic mclk, rst_n, can_mode, rx_valid, rx_ready, cmd_valid, cmd_done;
	logic tx_valid, tx_last, tx_ready, tx_enable;
	logic [7:0] module_addr, reply_addr, rx_data, cmd_status, tx_data, st;
	logic [31:0] cmd_result;
	mcf_core_t cmd_core;
	logic [8:0] exp_q[$];
	mcf_core_t core_q[$];
	int n_errors, samples_checked;
	mcf_interp u_dut (.mclk(mclk), .rst_n(rst_n), .can_mode(can_mode),
		.module_addr(module_addr), .reply_addr(reply_addr), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready), .cmd_valid(cmd_valid), .cmd_core(cmd_core),
		.cmd_done(cmd_done), .cmd_status(cmd_status), .cmd_result(cmd_result),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
		.tx_enable(tx_enable));
	mcf_exec_model u_exec (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_core(cmd_core),
		.status(st), .cmd_done(cmd_done), .cmd_status(cmd_status),
		.cmd_result(cmd_result), .tx_ready(tx_ready));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic close_out();
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic miss(input string m);
		n_errors++;
		$display("wrong value at %0t: %s", $time, m);
	endtask
	task automatic chk_byte(input logic [8:0] got);
		samples_checked++;
		if (exp_q.size() == 0) miss("unasked reply byte");
		else if (got !== exp_q.pop_front()) miss("reply byte");
	endtask
	task automatic chk_core(input mcf_core_t got);
		samples_checked++;
		if (core_q.size() == 0) miss("unasked command");
		else if (got !== core_q.pop_front()) miss("command fields");
	endtask
	always @(posedge mclk) begin
		if (rst_n === 1'b1 && tx_valid === 1'b1 && tx_ready === 1'b1) begin
			chk_byte({tx_last, tx_data});
		end
		if (rst_n === 1'b1 && cmd_valid === 1'b1) begin
			chk_core(cmd_core);
		end
	end
	task automatic send(input logic can, input logic [7:0] addr, input mcf_core_t c,
		input bit bad);
		logic [7:0] f[$];
		logic [7:0] r[$];
		logic [7:0] sum;
		logic [7:0] es;
		logic [31:0] v;
		int k;
		can_mode = can;
		// Straps pass a synchroniser and a settle check before the first byte
		repeat (6) @(posedge mclk);
		#1;
		v = bad ? 32'h0 : ~c.value;
		// An executor code outside the set comes back as not available
		es = bad ? 8'h01 : ((st == 8'h7F) ? 8'h06 : st);
		f = {c.cmd, c.typ, c.bank, c.value[31:24], c.value[23:16], c.value[15:8], c.value[7:0]};
		r = {module_addr, es, c.cmd, v[31:24], v[23:16], v[15:8], v[7:0]};
		if (!can) begin
			f.push_front(addr);
			sum = 8'h00;
			foreach (f[i]) sum += f[i];
			f.push_back(bad ? ~sum : sum);
			r.push_front(reply_addr);
			sum = 8'h00;
			foreach (r[i]) sum += r[i];
			r.push_back(sum);
		end
		if (can || addr == module_addr) begin
			if (!bad) core_q.push_back(c);
			foreach (r[i]) exp_q.push_back({i == r.size() - 1, r[i]});
		end
		foreach (f[i]) begin
			rx_valid = 1'b1;
			rx_data = f[i];
			k = 0;
			do begin
				@(posedge mclk);
				k++;
			end while (rx_ready !== 1'b1 && k < 50);
			if (k >= 50) miss("byte never taken");
			#1;
		end
		rx_valid = 1'b0;
		k = 0;
		// Host holds off until the whole reply is in and the bus is released
		while ((exp_q.size() > 0 || tx_enable !== 1'b0) && k < 300) begin
			@(posedge mclk);
			k++;
		end
		if (k >= 300) miss("reply never finished");
		repeat (4) @(posedge mclk);
		#1;
	endtask
	initial begin
		logic [7:0] stl [8];
		logic [63:0] rnd;
		logic [7:0] a8;
		stl = '{8'h64, 8'h65, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
		rst_n = 1'b0;
		can_mode = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		module_addr = 8'h2A;
		reply_addr = 8'h02;
		st = 8'h64;
		void'($urandom(32'h1CC3));
		repeat (8) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		// 0..7 every status, 8..9 CAN (9 with an unknown code), 10 bad sum, 11 foreign
		for (int i = 0; i < 12; i++) begin
			rnd = {$urandom(), $urandom()};
			st = (i == 9) ? 8'h7F : stl[i % 8];
			reply_addr = rnd[63:56];
			a8 = (i == 11) ? ~module_addr : module_addr;
			send(i == 8 || i == 9, a8, rnd[55:0], i == 10);
		end
		close_out();
	end
	initial begin
		#500000;
		miss("run timed out");
		close_out();
	end
endmodule
bind mcf_interp mcf_interp_props u_props (.mclk(mclk), .rst_n(rst_n), .rx_ready(rx_ready),
	.cmd_valid(cmd_valid), .cmd_done(cmd_done), .tx_valid(tx_valid), .tx_last(tx_last),
	.tx_data(tx_data), .tx_ready(tx_ready), .tx_enable(tx_enable));
